// file: rtl/nv_port_pkg.sv
// Constants for the nonvolatile byte access port.
// Assumes one 250 MHz core clock and a 6-bit I/O register address space.
package nv_port_pkg;
  // Storage geometry
  localparam int unsigned NV_BYTES   = 512;
  localparam int unsigned NV_ADDR_W  = 9;
  localparam int unsigned IO_ADDR_W  = 6;
  // I/O register addresses
  localparam logic [5:0] IO_NV_CONTROL      = 6'h1c;
  localparam logic [5:0] IO_NV_DATA_BYTE    = 6'h1d;
  localparam logic [5:0] IO_NV_ADDRESS_LOW  = 6'h1e;
  localparam logic [5:0] IO_NV_ADDRESS_HIGH = 6'h1f;
  // Control register field positions
  localparam int unsigned CTL_READ_STROBE_BIT  = 0;
  localparam int unsigned CTL_WRITE_STROBE_BIT = 1;
  localparam int unsigned CTL_UNLOCK_BIT       = 2;
  localparam int unsigned CTL_READY_IE_BIT     = 3;
  localparam logic        READY_IE_RESET       = 1'b0;
  // Core cycle counts
  localparam logic [2:0] UNLOCK_WINDOW_CYC = 3'h4;
  localparam logic [2:0] READ_STALL_CYC    = 3'h4;
  localparam logic [2:0] WRITE_STALL_CYC   = 3'h2;
  // Write timing: oscillator cycles of the calibrated source
  localparam int unsigned CLK_FREQ_HZ   = 250_000_000;
  localparam int unsigned OSC_FREQ_HZ   = 1_000_000;
  localparam int unsigned OSC_DIV_CYC   = CLK_FREQ_HZ / OSC_FREQ_HZ;
  localparam int unsigned WRITE_OSC_CYC = 8448;
endpackage : nv_port_pkg

// file: rtl/nv_write_timer.sv
// Self-timed write interval: a prescaler makes the oscillator tick from
// the core clock, then a tick counter measures the programming time.
// Assumes i_start is a one-cycle pulse from the same clock.
`timescale 1ns/1ps
`default_nettype none
module nv_write_timer #(
  parameter int unsigned DIV_CYC = 250,
  parameter int unsigned TICKS   = 8448
) (
  input  wire logic i_clk,    // Core clock
  input  wire logic i_rstn,   // Async reset, active low
  input  wire logic i_start,  // Start pulse
  output logic      o_busy,   // Interval running
  output logic      o_done    // Pulse at interval end
);
  localparam int unsigned PRE_W  = $clog2(DIV_CYC + 1);
  localparam int unsigned TICK_W = $clog2(TICKS + 1);
  localparam logic [PRE_W-1:0]  PRE_LAST  = PRE_W'(DIV_CYC - 1);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICKS - 1);

  logic [PRE_W-1:0]  pre_reg;
  logic [TICK_W-1:0] tick_reg;
  logic              pre_wrap;

  assign pre_wrap = (pre_reg == PRE_LAST);

  // Prescaler and tick count; a start while busy is dropped
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pre_reg  <= '0;
      tick_reg <= '0;
      o_busy   <= 1'b0;
      o_done   <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (!o_busy) begin
        if (i_start) begin
          pre_reg  <= '0;
          tick_reg <= '0;
          o_busy   <= 1'b1;
        end
      end else if (pre_wrap) begin
        pre_reg <= '0;
        if (tick_reg == TICK_LAST) begin
          o_busy <= 1'b0;
          o_done <= 1'b1;
        end else begin
          tick_reg <= tick_reg + 1'b1;
        end
      end else begin
        pre_reg <= pre_reg + 1'b1;
      end
    end
  end
endmodule : nv_write_timer
`default_nettype wire

// file: rtl/nv_byte_port.sv
// Nonvolatile byte access port: 512-byte store reached through four
// I/O registers, with unlocked self-timed writes and immediate reads.
// Assumes the core issues single-cycle I/O strobes on the same clock and
// honours o_cpu_stall by holding its next instruction.
`timescale 1ns/1ps
`default_nettype none
module nv_byte_port
  import nv_port_pkg::*;
#(
  parameter int unsigned OSC_DIV   = OSC_DIV_CYC,
  parameter int unsigned WRITE_OSC = WRITE_OSC_CYC
) (
  input  wire logic       i_clk,       // Core clock, 250 MHz
  input  wire logic       i_rstn,      // Async reset, active low
  input  wire logic [5:0] i_io_addr,   // I/O register address
  input  wire logic       i_io_wr,     // I/O write strobe
  input  wire logic       i_io_rd,     // I/O read strobe
  input  wire logic [7:0] i_io_wdata,  // I/O write data
  output logic      [7:0] o_io_rdata,  // Read data, next cycle
  output logic            o_cpu_stall, // Hold next instruction
  output logic            o_ready_irq  // Ready interrupt level
);
  // Storage and registers
  // The array has no reset, so stored bytes survive a reset
  logic [7:0]           mem [NV_BYTES];
  logic                 addr_high_reg;
  logic [7:0]           addr_low_reg;
  logic [7:0]           data_reg;
  logic                 ready_ie_reg;
  logic [2:0]           unlock_cnt_reg;
  logic [2:0]           stall_cnt_reg;
  logic [NV_ADDR_W-1:0] wr_addr_reg;
  logic [7:0]           wr_data_reg;

  // Decoded strobes
  logic                 sel_ctl;
  logic                 sel_data;
  logic                 sel_low;
  logic                 sel_high;
  logic                 bit_read;
  logic                 bit_write;
  logic                 bit_unlock;
  logic                 bit_ie;
  logic                 rd_hits_done;
  logic                 ctl_wr;
  logic                 unlock_on;
  logic                 busy;
  logic                 wr_done;
  logic                 wr_start;
  logic                 rd_start;
  logic [NV_ADDR_W-1:0] nv_address;
  logic [7:0]           ctl_rd_value;

  // Register selects; every other I/O address belongs to other blocks
  assign sel_ctl    = (i_io_addr == IO_NV_CONTROL);
  assign sel_data   = (i_io_addr == IO_NV_DATA_BYTE);
  assign sel_low    = (i_io_addr == IO_NV_ADDRESS_LOW);
  assign sel_high   = (i_io_addr == IO_NV_ADDRESS_HIGH);

  // Control write fields, meaningful only together with ctl_wr
  assign bit_read   = i_io_wdata[CTL_READ_STROBE_BIT];
  assign bit_write  = i_io_wdata[CTL_WRITE_STROBE_BIT];
  assign bit_unlock = i_io_wdata[CTL_UNLOCK_BIT];
  assign bit_ie     = i_io_wdata[CTL_READY_IE_BIT];

  assign nv_address = {addr_high_reg, addr_low_reg};
  assign ctl_wr     = i_io_wr && sel_ctl;
  assign unlock_on  = (unlock_cnt_reg != 3'h0);
  // Strobe only counts with unlock already open and no write running
  assign wr_start   = ctl_wr && bit_write
                      && unlock_on && !busy;
  // Reads are dropped while the array is being programmed
  assign rd_start   = ctl_wr && bit_read && !busy;
  // The array takes the byte one edge after busy falls, so a read in
  // that edge would miss it; the captured byte is forwarded instead
  assign rd_hits_done = wr_done && (nv_address == wr_addr_reg);

  // Control readback: strobe bit mirrors busy, read strobe reads as zero
  assign ctl_rd_value = {4'h0, ready_ie_reg, unlock_on, busy, 1'b0};

  // Write interval timer
  // Ticks come from the core clock, so OSC_DIV must follow its frequency
  nv_write_timer #(
    .DIV_CYC (OSC_DIV),
    .TICKS   (WRITE_OSC)
  ) u_timer (
    .i_clk   (i_clk),
    .i_rstn  (i_rstn),
    .i_start (wr_start),
    .o_busy  (busy),
    .o_done  (wr_done)
  );

  // Address registers carry no reset; software must load them first
  // A write in progress freezes the address so the target cannot move
  always_ff @(posedge i_clk) begin
    if (i_io_wr && !busy) begin
      if (sel_high) begin
        addr_high_reg <= i_io_wdata[0];
      end
      if (sel_low) begin
        addr_low_reg <= i_io_wdata;
      end
    end
  end

  // Data register: written by software or loaded by a read
  always_ff @(posedge i_clk) begin
    if (rd_start && rd_hits_done) begin
      data_reg <= wr_data_reg;
    end else if (rd_start) begin
      data_reg <= mem[nv_address];
    end else if (i_io_wr && sel_data) begin
      data_reg <= i_io_wdata;
    end
  end

  // Capture the target at start so later register writes cannot corrupt it
  // The data register stays free for software during the write
  always_ff @(posedge i_clk) begin
    if (wr_start) begin
      wr_addr_reg <= nv_address;
      wr_data_reg <= data_reg;
    end
  end

  // Array update at the end of the timed interval
  always_ff @(posedge i_clk) begin
    if (wr_done) begin
      mem[wr_addr_reg] <= wr_data_reg;
    end
  end

  // Ready interrupt enable
  // Every control write rewrites it, so software keeps it in each write
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ready_ie_reg <= READY_IE_RESET;
    end else if (ctl_wr) begin
      ready_ie_reg <= bit_ie;
    end
  end

  // Unlock window: a set opens four cycles, a zero write closes it
  // A starting write with the unlock bit re-arms it; harmless, as busy blocks a second start
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      unlock_cnt_reg <= 3'h0;
    end else if (ctl_wr) begin
      unlock_cnt_reg <= bit_unlock ? UNLOCK_WINDOW_CYC : 3'h0;
    end else if (unlock_on) begin
      unlock_cnt_reg <= unlock_cnt_reg - 3'h1;
    end
  end

  // Core stall: four cycles for a read, two for a write start
  // A read outranks a start when one control write carries both
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      stall_cnt_reg <= 3'h0;
      o_cpu_stall   <= 1'b0;
    end else if (rd_start) begin
      stall_cnt_reg <= READ_STALL_CYC - 3'h1;
      o_cpu_stall   <= 1'b1;
    end else if (wr_start) begin
      stall_cnt_reg <= WRITE_STALL_CYC - 3'h1;
      o_cpu_stall   <= 1'b1;
    end else if (stall_cnt_reg != 3'h0) begin
      stall_cnt_reg <= stall_cnt_reg - 3'h1;
      o_cpu_stall   <= 1'b1;
    end else begin
      o_cpu_stall   <= 1'b0;
    end
  end

  // Ready interrupt is a level, not a flag: no clear needed
  // Registered, so the level trails busy by one cycle
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_ready_irq <= 1'b0;
    end else begin
      o_ready_irq <= ready_ie_reg && !busy;
    end
  end

  // Register readback, one cycle after the read strobe
  // Reads have no side effects, so polling the control register is safe
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_io_rdata <= 8'h00;
    end else if (i_io_rd) begin
      unique case (i_io_addr)
        IO_NV_ADDRESS_HIGH: o_io_rdata <= {7'h00, addr_high_reg};
        IO_NV_ADDRESS_LOW:  o_io_rdata <= addr_low_reg;
        IO_NV_DATA_BYTE:    o_io_rdata <= data_reg;
        IO_NV_CONTROL:      o_io_rdata <= ctl_rd_value;
        default:            o_io_rdata <= 8'h00;
      endcase
    end else begin
      o_io_rdata <= 8'h00;
    end
  end
endmodule : nv_byte_port
`default_nettype wire

// file: verification/nv_byte_port_chk.sv
// Checker for the nonvolatile byte port, bound to its top module.
// Assumes the core waits out a stall before its next access.
`timescale 1ns/1ps
`default_nettype none
module nv_byte_port_chk
  import nv_port_pkg::*;
#(
  parameter int unsigned OSC_DIV   = 250,
  parameter int unsigned WRITE_OSC = 8448
) (
  input wire logic       i_clk,       // Clock
  input wire logic       i_rstn,      // Reset
  input wire logic [5:0] i_io_addr,   // Address
  input wire logic       i_io_wr,     // Write
  input wire logic       i_io_rd,     // Read
  input wire logic [7:0] i_io_wdata,  // Wdata
  input wire logic [7:0] o_io_rdata,  // Rdata
  input wire logic       o_cpu_stall, // Stall
  input wire logic       o_ready_irq  // Ready
);
  logic [2:0]  win_reg;  // Unlock cycles left
  logic [31:0] busy_reg; // Write cycles left
  logic        ie_reg;   // Enable copy
  logic        ctl, rd_c, busy, wr_go, rd_go;
  assign ctl   = i_io_wr && i_io_addr == IO_NV_CONTROL;
  assign rd_c  = i_io_rd && i_io_addr == IO_NV_CONTROL;
  assign busy  = busy_reg != 32'h0000_0000;
  assign wr_go = ctl && i_io_wdata[1] && win_reg != 3'h0 && !busy;
  assign rd_go = ctl && i_io_wdata[0] && !busy && !wr_go;
  // Shadow state, rebuilt from port traffic alone
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      win_reg  <= 3'h0;
      busy_reg <= 32'h0000_0000;
      ie_reg   <= 1'b0;
    end else begin
      if (ctl) win_reg <= i_io_wdata[2] ? 3'h4 : 3'h0;
      else if (win_reg != 3'h0) win_reg <= win_reg - 3'h1;
      if (wr_go) busy_reg <= OSC_DIV * WRITE_OSC;
      else if (busy) busy_reg <= busy_reg - 32'h0000_0001;
      if (ctl) ie_reg <= i_io_wdata[3];
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  a_read_stall: assert property (rd_go |=> o_cpu_stall [*4] ##1 !o_cpu_stall) else $error("read stall");
  a_write_stall: assert property (wr_go && !i_io_wdata[0] |=> o_cpu_stall [*2] ##1 !o_cpu_stall)
    else $error("write stall");
  a_refused_quiet: assert property (ctl && !wr_go && !rd_go && !o_cpu_stall |=> !o_cpu_stall)
    else $error("refused stall");
  a_rdata_idle: assert property ($past(!i_io_rd) |-> o_io_rdata == 8'h00) else $error("rdata idle");
  a_high_reserved: assert property ($past(i_io_rd && i_io_addr == IO_NV_ADDRESS_HIGH) |-> o_io_rdata[7:1] == 7'h00)
    else $error("high bits");
  a_busy_bit: assert property ($past(rd_c) |-> o_io_rdata[1] == $past(busy)) else $error("busy bit");
  a_unlock_bit: assert property ($past(rd_c) |-> o_io_rdata[2] == $past(win_reg != 3'h0))
    else $error("unlock bit");
  a_irq_level: assert property (o_ready_irq == $past(ie_reg && !busy)) else $error("ready level");
  c_write: cover property (wr_go);
  c_read: cover property (rd_go);
  c_refused: cover property (ctl && i_io_wdata[1] && busy);
endmodule : nv_byte_port_chk
bind nv_byte_port nv_byte_port_chk #(.OSC_DIV(OSC_DIV), .WRITE_OSC(WRITE_OSC)) nv_byte_port_chk_inst (
  .i_clk(i_clk), .i_rstn(i_rstn), .i_io_addr(i_io_addr), .i_io_wr(i_io_wr), .i_io_rd(i_io_rd),
  .i_io_wdata(i_io_wdata), .o_io_rdata(o_io_rdata), .o_cpu_stall(o_cpu_stall), .o_ready_irq(o_ready_irq));
`default_nettype wire

// file: verification/nv_core_model.sv
// Core model issuing single-cycle I/O accesses, paced by the stall.
// Assumes strobes are sampled on the rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module nv_core_model
  import nv_port_pkg::*;
(
  input  wire logic       i_clk,   // Clock
  input  wire logic       i_stall, // Port holds core
  input  wire logic [7:0] i_rdata, // Read data
  output logic      [5:0] o_addr,  // Address
  output logic            o_wr,    // Write
  output logic            o_rd,    // Read
  output logic      [7:0] o_wdata  // Write data
);
  initial {o_addr, o_wr, o_rd, o_wdata} = 16'h0000;
  // One access; a stalled core issues nothing
  task automatic io(input logic [5:0] a, input logic w, input logic [7:0] d, output logic [7:0] q);
    @(negedge i_clk);
    while (i_stall) @(negedge i_clk);
    {o_addr, o_wr, o_rd, o_wdata} = {a, w, !w, d};
    @(negedge i_clk);
    q = i_rdata;
    // Released bus shows the inverse, never a stale value
    {o_addr, o_wr, o_rd, o_wdata} = {~a, 2'b00, ~d};
  endtask : io
  // Byte write: address, data, then unlock and strobe back to back
  task automatic put(input logic [8:0] a, input logic [7:0] d);
    logic [7:0] q;
    io(IO_NV_ADDRESS_HIGH, 1'b1, {7'h00, a[8]}, q);
    io(IO_NV_ADDRESS_LOW, 1'b1, a[7:0], q);
    io(IO_NV_DATA_BYTE, 1'b1, d, q);
    io(IO_NV_CONTROL, 1'b1, 8'h04, q);
    io(IO_NV_CONTROL, 1'b1, 8'h06, q);
  endtask : put
  // Byte read: address, read strobe, then the data register
  task automatic get(input logic [8:0] a, output logic [7:0] q);
    io(IO_NV_ADDRESS_HIGH, 1'b1, {7'h00, a[8]}, q);
    io(IO_NV_ADDRESS_LOW, 1'b1, a[7:0], q);
    io(IO_NV_CONTROL, 1'b1, 8'h01, q);
    io(IO_NV_DATA_BYTE, 1'b0, 8'h00, q);
  endtask : get
endmodule : nv_core_model
`default_nettype wire

// file: verification/nv_byte_port_tb.sv
// Bench for the nonvolatile byte port, driven through the core model.
// Assumes a write time shortened to 40 cycles by the port parameters.
`timescale 1ns/1ps
`default_nettype none
module nv_byte_port_tb;
  import nv_port_pkg::*;
  typedef struct packed {logic [8:0] a; logic [7:0] d;} row_s;
  // Address corners and the byte each should hold
  localparam row_s ROWS [4] = '{'{9'h000, 8'ha5}, '{9'h1ff, 8'h5a}, '{9'h100, 8'hff}, '{9'h0ff, 8'h00}};
  logic       i_clk  = 1'b0;
  logic       i_rstn = 1'b0;
  logic [5:0] addr;
  logic       wr, rd, stall, irq;
  logic [7:0] wdata, rdata, q;
  int         mismatches = 0;
  int         n_tests    = 0;
  always #2 i_clk = ~i_clk;
  nv_byte_port #(.OSC_DIV(2), .WRITE_OSC(20)) nv_byte_port_inst (.i_clk(i_clk), .i_rstn(i_rstn),
    .i_io_addr(addr), .i_io_wr(wr), .i_io_rd(rd), .i_io_wdata(wdata), .o_io_rdata(rdata),
    .o_cpu_stall(stall), .o_ready_irq(irq));
  nv_core_model nv_core_model_inst (.i_clk(i_clk), .i_stall(stall), .i_rdata(rdata), .o_addr(addr),
    .o_wr(wr), .o_rd(rd), .o_wdata(wdata));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic io(input logic [5:0] a, input logic w, input logic [7:0] d);
    nv_core_model_inst.io(a, w, d, q);
  endtask : io
  // Control reads have no side effect, so polling is safe
  task automatic rc(input string n, input logic [7:0] e);
    io(IO_NV_CONTROL, 1'b0, 8'h00);
    chk(n, e, q);
  endtask : rc
  task automatic idle;
    io(IO_NV_CONTROL, 1'b0, 8'h00);
    repeat (100) if (q[1]) io(IO_NV_CONTROL, 1'b0, 8'h00);
  endtask : idle
  task automatic test_done;
    $display("Comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : test_done
  // Watchdog, far beyond the few hundred cycles needed
  initial begin
    #40000;
    mismatches++;
    test_done();
  end
  initial begin
    repeat (10) @(negedge i_clk);
    i_rstn = 1'b1;
    rc("ctl_reset", 8'h00);
    chk("irq_reset", 8'h00, {7'h00, irq});
    io(IO_NV_ADDRESS_HIGH, 1'b1, 8'hff);
    io(IO_NV_ADDRESS_HIGH, 1'b0, 8'h00);
    chk("addr_high", 8'h01, q);
    io(6'h00, 1'b0, 8'h00);
    chk("unmapped", 8'h00, q);
    $display("Reset test done");
    foreach (ROWS[i]) begin
      nv_core_model_inst.put(ROWS[i].a, ROWS[i].d);
      idle();
      nv_core_model_inst.get(ROWS[i].a, q);
      chk("row_data", ROWS[i].d, q);
    end
    nv_core_model_inst.get(9'h000, q);
    chk("bit8_alias", 8'ha5, q);
    $display("Row test done");
    // Strobe with no unlock, then after the window has shut
    io(IO_NV_DATA_BYTE, 1'b1, 8'h11);
    io(IO_NV_CONTROL, 1'b1, 8'h02);
    rc("no_unlock", 8'h00);
    io(IO_NV_CONTROL, 1'b1, 8'h04);
    rc("unlock_open", 8'h04);
    repeat (4) @(negedge i_clk);
    io(IO_NV_CONTROL, 1'b1, 8'h02);
    rc("late_strobe", 8'h00);
    nv_core_model_inst.get(9'h000, q);
    chk("kept", 8'ha5, q);
    $display("Unlock test done");
    // Address change, read and restart all ignored mid-write
    nv_core_model_inst.put(9'h0ff, 8'h3c);
    io(IO_NV_CONTROL, 1'b0, 8'h00);
    chk("busy", 8'h02, q & 8'h02);
    io(IO_NV_ADDRESS_LOW, 1'b1, 8'h00);
    io(IO_NV_DATA_BYTE, 1'b1, 8'h77);
    io(IO_NV_CONTROL, 1'b1, 8'h01);
    io(IO_NV_CONTROL, 1'b1, 8'h04);
    io(IO_NV_CONTROL, 1'b1, 8'h02);
    idle();
    io(IO_NV_ADDRESS_LOW, 1'b0, 8'h00);
    chk("addr_held", 8'hff, q);
    io(IO_NV_DATA_BYTE, 1'b0, 8'h00);
    chk("read_ignored", 8'h77, q);
    nv_core_model_inst.get(9'h0ff, q);
    chk("first_write", 8'h3c, q);
    $display("Busy test done");
    // Ready level follows the enable and drops while busy
    io(IO_NV_CONTROL, 1'b1, 8'h08);
    rc("ie_set", 8'h08);
    chk("irq_on", 8'h01, {7'h00, irq});
    io(IO_NV_CONTROL, 1'b1, 8'h0c);
    io(IO_NV_CONTROL, 1'b1, 8'h0e);
    io(IO_NV_CONTROL, 1'b0, 8'h00);
    chk("irq_busy", 8'h00, {7'h00, irq});
    idle();
    chk("irq_back", 8'h01, {7'h00, irq});
    $display("Ready test done");
    // Reset in mid-write drops the write, the stall and the enable
    io(IO_NV_CONTROL, 1'b1, 8'h0c);
    io(IO_NV_CONTROL, 1'b1, 8'h0e);
    @(negedge i_clk);
    i_rstn = 1'b0;
    @(negedge i_clk);
    i_rstn = 1'b1;
    rc("reset_abort", 8'h00);
    chk("irq_reset_mid", 8'h00, {7'h00, irq});
    $display("Reset abort test done");
    test_done();
  end
endmodule : nv_byte_port_tb
`default_nettype wire
